// ---- adr_readout.sv ----
// Summary of operation
// - Chain select turns status pin into chain input.
// - Chain input reaches output after 16/24 clocks.
// - First word after select fall is own result.
// - Later words carry upstream data in order.
// - Without upstream, own result repeats every word.
// - Select toggled between words restarts own result.
// - Untriggered converter forwards its previous result.
// - Plain mode frame is 16 clocks.
// - Tagged plain frame: tag, then seven zeros.
// - Chain frame is 16 or 24 clocks.
// - Power-on or soft reset bit resets device.
// - Reset sets configuration bits to all ones.
// - First frame after reset outputs all ones.
// - Reset returns state machine to power-on state.
// - Chain bit zero selects chain input mode.
// - Tag bit appears at seventeenth serial clock.
// - Result MSB first, then two zeros, tag.
`timescale 1ns/1ps
`default_nettype none

module adr_readout #(
  parameter int FIFO_DEPTH = adr_pkg::FIFO_DEPTH
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_reset_n,
  input  wire logic                       i_sclk,
  input  wire logic                       i_cs_n,
  input  wire logic                       i_status_pin,
  output logic                            o_status_pin,
  output logic                            o_status_pin_oe,
  output logic                            o_sdo,
  output logic                            o_sdo_oe,
  input  wire logic                       i_eoc,
  input  wire logic                       i_config_load,
  input  wire logic [adr_pkg::CFG_W-1:0]  i_config_word,
  output logic      [adr_pkg::CFG_W-1:0]  o_config_word,
  input  wire logic                       i_result_valid,
  input  wire adr_pkg::adr_sample_type    i_result,
  output logic                            o_result_ready
);

  import adr_pkg::*;

  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("adr_readout needs a result buffer of at least two words");
  end

  typedef struct packed {
    logic [PIN_W-1:0]  s1;
    logic [PIN_W-1:0]  s2;
    logic [PIN_W-1:0]  s3;
    logic [PIN_W-1:0]  stable;
    logic [PIN_W-1:0]  stable_d;
    logic [CFG_W-1:0]  cfg;
    adr_sample_type    sample;
    adr_phase_type     phase;
    logic              after_reset;
    logic              cdi_cap;
    logic [WORD_W-1:0] word;
    logic              sdo;
    logic              sdo_oe;
    logic              status;
    logic              status_oe;
    logic              result_ready;
  } adr_regs_type;

  localparam adr_regs_type REGS_RESET = '{
    s1:           '0,
    s2:           '0,
    s3:           '0,
    stable:       '0,
    stable_d:     '0,
    cfg:          CFG_RESET,
    sample:       '0,
    phase:        ST_IDLE,
    after_reset:  1'b1,
    cdi_cap:      1'b0,
    word:         '0,
    sdo:          1'b0,
    sdo_oe:       1'b0,
    status:       1'b0,
    status_oe:    1'b1,
    result_ready: 1'b0
  };

  adr_regs_type   r;
  adr_regs_type   next_r;
  logic           fifo_in_ready;
  logic           fifo_valid;
  adr_sample_type fifo_data;
  logic           fifo_pop;

  // ------------------------------------------------------------------
  // Result buffer between the converter core and the serial port
  // ------------------------------------------------------------------
  adr_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (i_result_valid),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (i_result),
    .o_out_valid (fifo_valid),
    .i_out_ready (fifo_pop),
    .o_out_data  (fifo_data)
  );

  // The buffer only drains between frames, so a word never changes mid read.
  assign fifo_pop = fifo_valid && (r.phase == ST_IDLE);

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    logic       chain_on;
    logic       marker_on;
    logic [4:0] len;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_fall;
    logic       cs_rise;
    logic       insert;

    next_r = r;

    // A pin change counts once the second and third stages agree.
    next_r.s1       = {i_status_pin, i_cs_n, i_sclk};
    next_r.s2       = r.s1;
    next_r.s3       = r.s2;
    next_r.stable   = (r.s2 & r.s3) | (r.stable & (r.s2 | r.s3));
    next_r.stable_d = r.stable;

    sclk_rise = r.stable[PIN_SCLK] & ~r.stable_d[PIN_SCLK];
    sclk_fall = ~r.stable[PIN_SCLK] & r.stable_d[PIN_SCLK];
    cs_fall   = ~r.stable[PIN_CS] & r.stable_d[PIN_CS];
    cs_rise   = r.stable[PIN_CS] & ~r.stable_d[PIN_CS];

    chain_on  = ~r.cfg[BIT_CHAIN];
    marker_on = r.cfg[BIT_MARKER];
    len       = marker_on ? LEN_TAG : LEN_PLAIN;
    insert    = 1'b0;

    next_r.status       = i_eoc;
    next_r.status_oe    = r.cfg[BIT_CHAIN];
    next_r.result_ready = fifo_in_ready;

    // A new result replaces the held one only when the core produced one.
    if (fifo_pop) begin
      next_r.sample = fifo_data;
    end

    unique case (r.phase)
      ST_IDLE: begin
        if (cs_fall) begin
          next_r.phase  = ST_FRAME;
          next_r.sdo_oe = 1'b1;
          if (r.after_reset) begin
            next_r.word = '1;
          end else if (marker_on) begin
            next_r.word = {r.sample.code, PAD_W'(0), r.sample.tag, TAIL_W'(0)};
          end else begin
            next_r.word = {8'h00, r.sample.code, PAD_W'(0)};
          end
          next_r.sdo = next_r.word[len - 5'h01];
        end
      end
      ST_FRAME: begin
        if (sclk_rise) begin
          next_r.cdi_cap = r.stable[PIN_CDI];
        end
        if (sclk_fall) begin
          // Chain mode delays upstream bits by one frame; otherwise the word circulates.
          insert      = chain_on ? r.cdi_cap : r.word[len - 5'h01];
          next_r.word = {r.word[WORD_W-2:0], insert};
          next_r.sdo  = next_r.word[len - 5'h01];
        end
        if (cs_rise) begin
          next_r.phase       = ST_IDLE;
          next_r.sdo         = 1'b0;
          next_r.sdo_oe      = 1'b0;
          next_r.after_reset = 1'b0;
        end
      end
    endcase

    if (i_config_load) begin
      if (!i_config_word[BIT_SRST]) begin
        // Soft reset acts like power-on reset but leaves the pin samplers and the result buffer running.
        next_r        = REGS_RESET;
        next_r.s1     = {i_status_pin, i_cs_n, i_sclk};
        next_r.s2     = r.s1;
        next_r.s3     = r.s2;
        next_r.stable = r.stable;
        next_r.stable_d = r.stable;
        next_r.result_ready = fifo_in_ready;
      end else begin
        next_r.cfg = i_config_word;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r <= REGS_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign o_status_pin    = r.status;
  assign o_status_pin_oe = r.status_oe;
  assign o_sdo           = r.sdo;
  assign o_sdo_oe        = r.sdo_oe;
  assign o_config_word   = r.cfg;
  assign o_result_ready  = r.result_ready;

endmodule

`default_nettype wire

// ---- adr_pkg.sv ----
`default_nettype none

package adr_pkg;

  // ------------------------------------------------------------------
  // Configuration word
  // ------------------------------------------------------------------
  localparam int          CFG_W      = 12;
  localparam logic [11:0] CFG_RESET  = 12'hfff;
  localparam int          BIT_AUTO   = 11;
  localparam int          BIT_CHAIN  = 5;
  localparam int          BIT_MARKER = 1;
  localparam int          BIT_SRST   = 0;

  // ------------------------------------------------------------------
  // Result and frame layout
  // ------------------------------------------------------------------
  localparam int         RES_W     = 14;
  localparam int         WORD_W    = 24;
  localparam int         PAD_W     = 2;
  localparam int         TAIL_W    = 7;
  localparam logic [4:0] LEN_PLAIN = 5'h10;
  localparam logic [4:0] LEN_TAG   = 5'h18;
  localparam int         FIFO_DEPTH = 16;

  // ------------------------------------------------------------------
  // Pin synchroniser lanes
  // ------------------------------------------------------------------
  localparam int PIN_W    = 3;
  localparam int PIN_SCLK = 0;
  localparam int PIN_CS   = 1;
  localparam int PIN_CDI  = 2;

  typedef struct packed {
    logic             tag;
    logic [RES_W-1:0] code;
  } adr_sample_type;

  localparam int SAMPLE_W = $bits(adr_sample_type);

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_FRAME
  } adr_phase_type;

endpackage

`default_nettype wire

// ---- adr_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none

module adr_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] CNT_ONE  = CW'(1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
  localparam logic [PW-1:0] PTR_ONE  = PW'(1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("adr_fifo depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [CW-1:0]               count;
    logic                        not_full;
    logic                        not_empty;
  } adr_fifo_regs_type;

  adr_fifo_regs_type r;
  adr_fifo_regs_type next_r;
  logic              push;
  logic              pop;

  always_comb begin
    next_r = r;
    push   = i_in_valid & r.not_full;
    pop    = i_out_ready & r.not_empty;
    if (push) begin
      next_r.mem[r.wr] = i_in_data;
      next_r.wr        = r.wr + PTR_ONE;
    end
    if (pop) begin
      next_r.rd = r.rd + PTR_ONE;
    end
    if (push && !pop) begin
      next_r.count = r.count + CNT_ONE;
    end else if (pop && !push) begin
      next_r.count = r.count - CNT_ONE;
    end
    next_r.not_full  = (next_r.count != CNT_FULL);
    next_r.not_empty = (next_r.count != '0);
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r          <= '0;
      r.not_full <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign o_in_ready  = r.not_full;
  assign o_out_valid = r.not_empty;
  assign o_out_data  = r.mem[r.rd];

endmodule

`default_nettype wire

// ---- adr_readout_checker.sv ----
`timescale 1ns/1ps
`default_nettype none

module adr_readout_checker (
  input wire logic                      i_clk,
  input wire logic                      i_reset_n,
  input wire logic                      i_cs_n,
  input wire logic                      i_eoc,
  input wire logic                      i_config_load,
  input wire logic [adr_pkg::CFG_W-1:0] i_config_word,
  input wire logic [adr_pkg::CFG_W-1:0] o_config_word,
  input wire logic                      o_status_pin,
  input wire logic                      o_status_pin_oe,
  input wire logic                      o_sdo,
  input wire logic                      o_sdo_oe,
  input wire logic                      o_result_ready
);
  import adr_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  a_soft_reset_cfg: assert property (
    i_config_load && !i_config_word[BIT_SRST] |=> o_config_word == CFG_RESET)
    else $error("config not all ones after soft reset");
  a_cfg_load_store: assert property (
    i_config_load && i_config_word[BIT_SRST] |=> o_config_word == $past(i_config_word))
    else $error("config word not stored");
  a_chain_pin_dir: assert property (
    $past(i_reset_n) && !$past(i_config_load)
    |-> o_status_pin_oe == $past(o_config_word[BIT_CHAIN]))
    else $error("shared pin direction wrong");
  a_status_echo: assert property (
    $past(i_reset_n) && !$past(i_config_load) && o_status_pin_oe
    |-> o_status_pin == $past(i_eoc))
    else $error("status pin does not follow conversion end");
  a_idle_sdo_low: assert property (
    !o_sdo_oe |-> !o_sdo)
    else $error("serial output high outside frame");
  a_frame_opens: assert property (
    $fell(i_cs_n) ##1 !i_cs_n [*7] |=> o_sdo_oe)
    else $error("frame not opened after select fell");
  a_frame_closes: assert property (
    $rose(i_cs_n) ##1 i_cs_n [*7] |=> !o_sdo_oe)
    else $error("frame not closed after select rose");
  a_soft_reset_fsm: assert property (
    i_config_load && !i_config_word[BIT_SRST] |=> !o_sdo_oe && o_status_pin_oe)
    else $error("soft reset did not restore idle state");

  c_soft_reset: cover property (i_config_load && !i_config_word[BIT_SRST]);
  c_chain_frame: cover property (!o_status_pin_oe && o_sdo_oe);
  c_buffer_full: cover property (!o_result_ready);
endmodule

bind adr_readout adr_readout_checker i_adr_readout_checker (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_cs_n(i_cs_n), .i_eoc(i_eoc),
  .i_config_load(i_config_load), .i_config_word(i_config_word),
  .o_config_word(o_config_word), .o_status_pin(o_status_pin),
  .o_status_pin_oe(o_status_pin_oe), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
  .o_result_ready(o_result_ready));

`default_nettype wire

// ---- adr_upstream_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module adr_upstream_model (
  input  wire logic        i_sclk,
  input  wire logic        i_cs_n,
  input  wire logic [15:0] i_word,
  output logic             o_cdi
);
  logic [15:0] shreg;

  initial shreg = 16'h0000;
  // The first converter of the chain sends its word MSB first.
  // Left in regular mode, it repeats its own word while it stays selected.
  always @(negedge i_cs_n) shreg = i_word;
  always @(negedge i_sclk) begin
    if (!i_cs_n) shreg = {shreg[14:0], shreg[15]};
  end
  // Unselected, the line is not driven, so it shows the inverse level.
  assign o_cdi = shreg[15] ^ i_cs_n;
endmodule

`default_nettype wire

// ---- adr_readout_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module adr_readout_test;
  import adr_pkg::*;
  logic             clk;
  logic             rst_n;
  logic             sclk;
  logic             cs_n;
  logic             eoc = 1'b0;
  logic             load;
  logic             rv;
  logic [CFG_W-1:0] word;
  logic [CFG_W-1:0] cfg_o;
  adr_sample_type   res;
  logic [15:0]      up;
  logic [47:0]      d;
  logic             st;
  logic             st_oe;
  logic             sdo;
  logic             sdo_oe;
  logic             rdy;
  wire logic        chain_data_in;
  wire logic        pin;
  int               fails = 0;
  int               total_checks = 0;

  assign pin = st_oe ? st : chain_data_in;

  adr_readout i_adr_readout (
    .i_clk(clk), .i_reset_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_status_pin(pin), .o_status_pin(st), .o_status_pin_oe(st_oe),
    .o_sdo(sdo), .o_sdo_oe(sdo_oe), .i_eoc(eoc), .i_config_load(load),
    .i_config_word(word), .o_config_word(cfg_o), .i_result_valid(rv),
    .i_result(res), .o_result_ready(rdy));
  adr_upstream_model i_adr_upstream_model (
    .i_sclk(sclk), .i_cs_n(cs_n), .i_word(up), .o_cdi(chain_data_in));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(negedge clk) eoc <= ~eoc;

  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic note(input string s);
    $display("test %s done", s);
  endtask

  task automatic cfg(input logic [CFG_W-1:0] w);
    @(negedge clk) load = 1'b1;
    word = w;
    @(negedge clk) load = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task automatic push(input logic [14:0] w);
    @(negedge clk) rv = 1'b1;
    res = w;
    @(negedge clk) rv = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  // Serial clock of eight system clocks; bits are taken before it falls.
  task automatic xfer(input int n, output logic [47:0] q);
    q = '0;
    @(negedge clk) cs_n = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      @(negedge clk) sclk = 1'b1;
      repeat (4) @(negedge clk);
      q = {q[46:0], sdo};
      sclk = 1'b0;
      repeat (3) @(negedge clk);
    end
    @(negedge clk) cs_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    conclude();
  end

  initial begin
    {rst_n, sclk, cs_n, load, rv} = 5'b00100;
    word = '0;
    res = '0;
    up = 16'hc3a5;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    cmp(48'(cfg_o), 48'hfff);
    push(15'h6a5c);
    xfer(16, d);
    cmp(d, 48'hffff);
    xfer(24, d);
    cmp(d, 48'ha97080);
    note("reset and tag");
    cfg(12'hffd);
    push(15'h1337);
    xfer(32, d);
    cmp(d, 48'h4cdc4cdc);
    note("regular");
    cfg(12'hfdd);
    cmp(48'(st_oe), 48'h0);
    push(15'h0abc);
    xfer(32, d);
    cmp(d, 48'h2af0c3a5);
    cfg(12'hfdf);
    xfer(40, d);
    cmp(d, 48'h2af000c3a5);
    note("chain");
    cfg(12'hfdd);
    for (int k = 0; k < 2; k++) begin
      xfer(16, d);
      cmp(d, 48'h2af0);
    end
    note("select toggled");
    cfg(12'hffe);
    cmp(48'(cfg_o), 48'hfff);
    xfer(16, d);
    cmp(d, 48'hffff);
    note("soft reset");
    @(negedge clk) cs_n = 1'b0;
    repeat (8) @(negedge clk);
    for (int k = 0; k < 17; k++) push(15'(k));
    cmp(48'(rdy), 48'h0);
    @(negedge clk) cs_n = 1'b1;
    repeat (40) @(negedge clk);
    cmp(48'(rdy), 48'h1);
    xfer(16, d);
    cmp(d, 48'h3c);
    note("buffer");
    conclude();
  end
endmodule

`default_nettype wire
